// ### sim/pcu_regs_sva.sv
`timescale 1ns/1ps
`include "pcu_consts.vh"
// Property checker for the power control unit register bank
module pcu_regs_sva #(
	parameter AW = 14
) (
	input wire clk_i,
	input wire rst_i,
	input wire wb_we_i,
	input wire [AW-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire vbus_low_i,
	input wire vbusp_low_i,
	input wire contact_iface_on_o,
	input wire internal_pad_supply_on_o,
	input wire usb_line_sw_override_o,
	input wire [2:0] host_port_select_o,
	input wire host_port_invalid_o,
	input wire hard_powerdown_state_o,
	input wire contact_shutdown_start_o,
	input wire irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Low two lanes of the control word written at the ack edge
	wire sys_wr = wb_ack_o && wb_we_i && wb_adr_i == `PCU_OFS_SYSCTL
		&& wb_sel_i[1:0] == 2'h3;
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_reset_fields: assert property (
		$fell(rst_i) |-> contact_iface_on_o && !internal_pad_supply_on_o
		&& !usb_line_sw_override_o && host_port_select_o == 3'h0)
		else $error("control outputs wrong after reset");
	a_reset_quiet: assert property (
		$fell(rst_i) |-> !irq_o && !hard_powerdown_state_o
		&& !contact_shutdown_start_o)
		else $error("status outputs active after reset");
	a_sys_fields: assert property (
		sys_wr |-> ##2 {internal_pad_supply_on_o, contact_iface_on_o,
		usb_line_sw_override_o, host_port_select_o}
		== {$past(wb_dat_i[9:8], 2), $past(wb_dat_i[3:0], 2)})
		else $error("control outputs do not follow written word");
	a_invalid_code: assert property (
		host_port_invalid_o == (host_port_select_o > 3'h4))
		else $error("host port invalid flag wrong");
	a_pdown_cause: assert property (
		$rose(hard_powerdown_state_o) |-> $past(vbus_low_i))
		else $error("powerdown entered without low supply");
	a_pdown_sticky: assert property (
		hard_powerdown_state_o |=> hard_powerdown_state_o)
		else $error("powerdown state left without reset");
	a_shut_cause: assert property (
		contact_shutdown_start_o |-> $past(vbusp_low_i))
		else $error("shutdown started without low supply");
	a_shut_pulse: assert property (
		contact_shutdown_start_o |=> !contact_shutdown_start_o)
		else $error("shutdown start longer than one cycle");
	a_ack_single: assert property (
		wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_rdata_idle: assert property (
		!wb_ack_o |-> wb_dat_o == 32'h00000000)
		else $error("read data not zero outside ack");
	// Main scenarios reached
	c_sys_wr: cover property (sys_wr);
	c_irq: cover property ($rose(irq_o));
	c_pdown: cover property ($rose(hard_powerdown_state_o));
	c_shut: cover property (contact_shutdown_start_o);
endmodule // pcu_regs_sva

// ### sim/pcu_regs_tb.sv
`timescale 1ns/1ps
`include "pcu_consts.vh"
// Self-checking bench for the power control unit register bank
module pcu_regs_tb;
	typedef struct {logic [13:0] a; logic w; logic [31:0] d;} pcu_row_t;
	logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
	logic [13:0] wb_adr_i = 0;
	logic [3:0] wb_sel_i = 0;
	logic [31:0] wb_dat_i = 0, rd;
	logic vbus_low_i = 0, vbusp_low_i = 0;
	logic pad_supply_low_18_i = 0, pad_supply_low_33_i = 0;
	logic aux_pad_supply_low_18_i = 0, aux_pad_supply_low_33_i = 0;
	wire [31:0] wb_dat_o;
	wire [2:0] host_port_select_o;
	wire wb_ack_o, contact_iface_on_o, internal_pad_supply_on_o, irq_o;
	wire usb_line_sw_override_o, host_port_invalid_o;
	wire hard_powerdown_state_o, contact_shutdown_start_o;
	int err_total = 0, n_compared = 0, n_pulse = 0;
	// Ordinary accesses: writes carry data, reads carry the expected word
	pcu_row_t rows[16] = '{
		'{14'h0000, 0, 32'h0}, '{14'h000C, 0, 32'h100},
		'{14'h0000, 1, 32'hFFFFFFFF}, '{14'h0004, 1, 32'hA5A5A5A5},
		'{14'h0008, 1, 32'h5A5A5A5A}, '{14'h0000, 0, 32'hFFFFFFFF},
		'{14'h0004, 0, 32'hA5A5A5A5}, '{14'h0008, 0, 32'h5A5A5A5A},
		'{14'h000C, 1, 32'hFFFFFFFF}, '{14'h000C, 0, 32'hFFF},
		'{14'h3FE4, 1, 32'hF}, '{14'h3FE4, 0, 32'h0},
		'{14'h3FE8, 0, 32'h0}, '{14'h3FEC, 0, 32'h0},
		'{14'h0010, 1, 32'hFF}, '{14'h0010, 0, 32'h0}};

	pcu_regs pcu_regs_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .vbus_low_i,
		.vbusp_low_i, .pad_supply_low_18_i, .pad_supply_low_33_i,
		.aux_pad_supply_low_18_i, .aux_pad_supply_low_33_i,
		.contact_iface_on_o, .internal_pad_supply_on_o,
		.usb_line_sw_override_o, .host_port_select_o, .host_port_invalid_o,
		.hard_powerdown_state_o, .contact_shutdown_start_o, .irq_o);

	// ------------------------------------------------------------
	// Clock, monitors and tasks
	// ------------------------------------------------------------
	initial forever #2 clk_i = ~clk_i;
	// Counts shutdown start pulses
	always @(negedge clk_i) if (contact_shutdown_start_o === 1'b1) n_pulse++;

	task summarize;
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// One classic cycle; read data is left in rd
	task automatic wb(input [13:0] a, input w, input [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <=
			{2'b11, w, a, 4'hF, d};
		// Ack and read data are taken at the rising edge that samples ack
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 20);
		rd = wb_dat_o;
		{wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
		// Later checks look at settled outputs, off the launching edge
		@(negedge clk_i);
		if (n >= 20) begin
			err_total++;
			$display("mismatch t=%0t no ack", $time);
			summarize();
		end
	endtask

	task rdchk(input [13:0] a, input [31:0] exp);
		wb(a, 0, 0);
		chk(rd, exp);
	endtask

	task settle(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		foreach (rows[k]) begin
			if (rows[k].w) wb(rows[k].a, 1, rows[k].d);
			else rdchk(rows[k].a, rows[k].d);
		end
		// Every host port code, invalid ones flagged
		for (int i = 0; i < 8; i++) begin
			wb(`PCU_OFS_SYSCTL, 1, i);
			settle(2);
			chk({host_port_invalid_o, host_port_select_o}, {i > 4, i[2:0]});
		end
		wb(`PCU_OFS_SYSCTL, 1, 32'h20B);
		settle(2);
		chk({internal_pad_supply_on_o, contact_iface_on_o,
			usb_line_sw_override_o, host_port_select_o}, 32'h2B);
		// Low supplies while not armed, then armed
		@(posedge clk_i);
		{vbus_low_i, vbusp_low_i} <= 2'b11;
		settle(3);
		chk({hard_powerdown_state_o, n_pulse[0]}, 0);
		wb(`PCU_OFS_SYSCTL, 1, 32'h400);
		settle(2);
		@(posedge clk_i);
		{vbus_low_i, vbusp_low_i} <= 2'b00;
		settle(2);
		chk(hard_powerdown_state_o, 1);
		wb(`PCU_OFS_SYSCTL, 1, 32'h800);
		@(posedge clk_i);
		vbusp_low_i <= 1;
		settle(4);
		chk(n_pulse, 1);
		rdchk(`PCU_OFS_IRQ_STATUS, 32'hC);
		chk(irq_o, 0);
		wb(`PCU_OFS_IRQ_FLAG_CLR, 1, 32'hF);
		rdchk(`PCU_OFS_IRQ_STATUS, 0);
		// Pad supply event, masking and flag writes
		wb(`PCU_OFS_IRQ_EN_SET, 1, 32'hF);
		wb(`PCU_OFS_SYSCTL, 1, 32'h010);
		@(posedge clk_i);
		pad_supply_low_18_i <= 1;
		settle(3);
		chk(irq_o, 1);
		rdchk(`PCU_OFS_IRQ_STATUS, 1);
		wb(`PCU_OFS_IRQ_EN_CLR, 1, 32'h1);
		settle(2);
		chk(irq_o, 0);
		wb(`PCU_OFS_IRQ_EN_SET, 1, 32'h1);
		settle(2);
		chk(irq_o, 1);
		wb(`PCU_OFS_IRQ_FLAG_CLR, 1, 32'h1);
		settle(2);
		chk(irq_o, 0);
		wb(`PCU_OFS_IRQ_FLAG_SET, 1, 32'h2);
		wb(`PCU_OFS_IRQ_FLAG_CLR, 1, 32'h0);
		rdchk(`PCU_OFS_IRQ_STATUS, 32'h2);
		wb(`PCU_OFS_IRQ_FLAG_CLR, 1, 32'h2);
		// Aux supply at the upper level: gated off, then on
		wb(`PCU_OFS_SYSCTL, 1, 32'h080);
		@(posedge clk_i);
		{aux_pad_supply_low_18_i, aux_pad_supply_low_33_i} <= 2'b01;
		settle(3);
		rdchk(`PCU_OFS_IRQ_STATUS, 0);
		wb(`PCU_OFS_SYSCTL, 1, 32'h0C0);
		@(posedge clk_i);
		aux_pad_supply_low_33_i <= 0;
		@(posedge clk_i);
		aux_pad_supply_low_33_i <= 1;
		settle(3);
		rdchk(`PCU_OFS_IRQ_STATUS, 32'h2);
		// Second reset in mid-run
		@(posedge clk_i);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rdchk(`PCU_OFS_SYSCTL, 32'h100);
		rdchk(`PCU_OFS_SCRATCH0, 0);
		chk({hard_powerdown_state_o, irq_o}, 0);
		summarize();
	end
endmodule // pcu_regs_tb

bind pcu_regs pcu_regs_sva #(.AW(AW)) pcu_regs_sva_i (.clk_i, .rst_i,
	.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
	.vbus_low_i,
	.vbusp_low_i, .contact_iface_on_o, .internal_pad_supply_on_o,
	.usb_line_sw_override_o, .host_port_select_o, .host_port_invalid_o,
	.hard_powerdown_state_o, .contact_shutdown_start_o, .irq_o);

// ### verilog/pcu_consts.vh
`ifndef PCU_CONSTS_VH
`define PCU_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCU_OFS_SCRATCH0 14'h0000
`define PCU_OFS_SCRATCH1 14'h0004
`define PCU_OFS_SCRATCH2 14'h0008
`define PCU_OFS_SYSCTL 14'h000C
`define PCU_OFS_IRQ_EN_CLR 14'h3FD8
`define PCU_OFS_IRQ_EN_SET 14'h3FDC
`define PCU_OFS_IRQ_STATUS 14'h3FE0
`define PCU_OFS_IRQ_EN_VIEW 14'h3FE4
`define PCU_OFS_IRQ_FLAG_CLR 14'h3FE8
`define PCU_OFS_IRQ_FLAG_SET 14'h3FEC

// ----------------------------------------------------------------
// System control fields
// ----------------------------------------------------------------
`define PCU_SYS_AUTO_CONTACT_SHUTDOWN 11
`define PCU_SYS_AUTO_HARD_POWERDOWN 10
`define PCU_SYS_INTERNAL_PAD_SUPPLY_ON 9
`define PCU_SYS_CONTACT_IFACE_ON 8
`define PCU_SYS_AUX_PAD_SUPPLY_LEVEL_SEL 7
`define PCU_SYS_AUX_PAD_SUPPLY_IRQ_ON 6
`define PCU_SYS_PAD_SUPPLY_LEVEL_SEL 5
`define PCU_SYS_PAD_SUPPLY_IRQ_ON 4
`define PCU_SYS_USB_LINE_SW_OVERRIDE 3
`define PCU_SYS_HOST_SEL_MSB 2
`define PCU_SYS_HOST_SEL_LSB 0
`define PCU_SYS_USED_MSB 11
`define PCU_SYS_RESET 12'h100
`define PCU_SCRATCH_RESET 32'h00000000

// ----------------------------------------------------------------
// Host port select codes
// ----------------------------------------------------------------
`define PCU_HOST_NONE 3'h0
`define PCU_HOST_I2C 3'h1
`define PCU_HOST_SPI 3'h2
`define PCU_HOST_FAST_UART 3'h3
`define PCU_HOST_USB 3'h4

// ----------------------------------------------------------------
// Interrupt bits
// ----------------------------------------------------------------
`define PCU_IRQ_BITS 4
`define PCU_IRQ_PAD_SUPPLY 0
`define PCU_IRQ_AUX_PAD_SUPPLY 1
`define PCU_IRQ_HARD_POWERDOWN 2
`define PCU_IRQ_CONTACT_SHUTDOWN 3
`define PCU_IRQ_RESET 4'h0

`endif

// ### verilog/pcu_irq_core.v
`timescale 1ns/1ps
// Sticky interrupt flags with enable mask and one level output
module pcu_irq_core #(
	parameter W = 4
) (
	input wire clk_i,
	input wire rst_i,
	input wire [W-1:0] event_i,
	input wire [W-1:0] flag_set_i,
	input wire [W-1:0] flag_clr_i,
	input wire [W-1:0] en_set_i,
	input wire [W-1:0] en_clr_i,
	output wire [W-1:0] status_o,
	output wire [W-1:0] enable_o,
	output reg irq_o
);
	reg [W-1:0] status_r;
	reg [W-1:0] enable_r;

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1) begin : g_bit
			// Set wins over clear so no event is lost
			always @(posedge clk_i) begin
				if (rst_i) begin
					status_r[g] <= 1'b0;
				end else if (event_i[g] | flag_set_i[g]) begin
					status_r[g] <= 1'b1;
				end else if (flag_clr_i[g]) begin
					status_r[g] <= 1'b0;
				end
			end
			// Enable mask, set and cleared by separate strobes
			always @(posedge clk_i) begin
				if (rst_i) begin
					enable_r[g] <= 1'b0;
				end else if (en_set_i[g]) begin
					enable_r[g] <= 1'b1;
				end else if (en_clr_i[g]) begin
					enable_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// Level interrupt while any enabled flag stands
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status_r & enable_r);
		end
	end

	assign status_o = status_r;
	assign enable_o = enable_r;
endmodule // pcu_irq_core

// ### verilog/pcu_regs.v
`timescale 1ns/1ps
`include "pcu_consts.vh"
// Power control unit register bank on a classic Wishbone slave
module pcu_regs #(
	parameter AW = 14
) (
	input wire clk_i,
	input wire rst_i,
	// Wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [AW-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Supply comparators, high while below the trip level
	input wire vbus_low_i,
	input wire vbusp_low_i,
	input wire pad_supply_low_18_i,
	input wire pad_supply_low_33_i,
	input wire aux_pad_supply_low_18_i,
	input wire aux_pad_supply_low_33_i,
	// Controls to the rest of the chip
	output reg contact_iface_on_o,
	output reg internal_pad_supply_on_o,
	output reg usb_line_sw_override_o,
	output reg [2:0] host_port_select_o,
	output reg host_port_invalid_o,
	output reg hard_powerdown_state_o,
	output reg contact_shutdown_start_o,
	output wire irq_o
);

	// ----------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------
	reg [31:0] scratch_value_0_r;
	reg [31:0] scratch_value_1_r;
	reg [31:0] scratch_value_2_r;
	reg [`PCU_SYS_USED_MSB:0] sysctl_r;
	reg [31:0] rdata_nxt;
	reg vbusp_low_r;

	wire req;
	wire wr_take;
	wire [31:0] bmask;
	wire [31:0] wmask_data;
	wire [`PCU_IRQ_BITS-1:0] ev;
	wire [`PCU_IRQ_BITS-1:0] mon_ev;
	wire [`PCU_IRQ_BITS-1:0] status;
	wire [`PCU_IRQ_BITS-1:0] enable;
	wire [`PCU_IRQ_BITS-1:0] wr_bits;
	wire sel_scratch0;
	wire sel_scratch1;
	wire sel_scratch2;
	wire sel_sysctl;
	wire sel_en_clr;
	wire sel_en_set;
	wire sel_flag_clr;
	wire sel_flag_set;
	wire vbus_trip;
	wire vbusp_trip;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------

	// A request is live while cycle and strobe are both high
	assign req = wb_cyc_i & wb_stb_i;
	// Writes commit on the edge where the master sees ack
	assign wr_take = req & wb_we_i & wb_ack_o;

	// Ack one cycle after the request, dropped the cycle after
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req & ~wb_ack_o;
		end
	end

	// Byte lane mask from the select lines
	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_lane
			assign bmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
		end
	endgenerate

	assign wmask_data = wb_dat_i & bmask;
	assign wr_bits = wmask_data[`PCU_IRQ_BITS-1:0];

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	assign sel_scratch0 = (wb_adr_i == `PCU_OFS_SCRATCH0);
	assign sel_scratch1 = (wb_adr_i == `PCU_OFS_SCRATCH1);
	assign sel_scratch2 = (wb_adr_i == `PCU_OFS_SCRATCH2);
	assign sel_sysctl = (wb_adr_i == `PCU_OFS_SYSCTL);
	assign sel_en_clr = (wb_adr_i == `PCU_OFS_IRQ_EN_CLR);
	assign sel_en_set = (wb_adr_i == `PCU_OFS_IRQ_EN_SET);
	assign sel_flag_clr = (wb_adr_i == `PCU_OFS_IRQ_FLAG_CLR);
	assign sel_flag_set = (wb_adr_i == `PCU_OFS_IRQ_FLAG_SET);

	// ----------------------------------------------------------------
	// Scratch words
	// ----------------------------------------------------------------

	// Plain storage with byte lanes, nothing else reads them
	always @(posedge clk_i) begin
		if (rst_i) begin
			scratch_value_0_r <= `PCU_SCRATCH_RESET;
			scratch_value_1_r <= `PCU_SCRATCH_RESET;
			scratch_value_2_r <= `PCU_SCRATCH_RESET;
		end else if (wr_take) begin
			if (sel_scratch0) begin
				scratch_value_0_r <= (scratch_value_0_r & ~bmask) | wmask_data;
			end
			if (sel_scratch1) begin
				scratch_value_1_r <= (scratch_value_1_r & ~bmask) | wmask_data;
			end
			if (sel_scratch2) begin
				scratch_value_2_r <= (scratch_value_2_r & ~bmask) | wmask_data;
			end
		end
	end

	// ----------------------------------------------------------------
	// System control
	// ----------------------------------------------------------------

	// Contact interface comes out of reset on, all else off
	always @(posedge clk_i) begin
		if (rst_i) begin
			sysctl_r <= `PCU_SYS_RESET;
		end else if (wr_take && sel_sysctl) begin
			sysctl_r <= (sysctl_r & ~bmask[`PCU_SYS_USED_MSB:0]) |
				wmask_data[`PCU_SYS_USED_MSB:0];
		end
	end

	// ----------------------------------------------------------------
	// Control outputs
	// ----------------------------------------------------------------

	// Registered copies of the configuration bits
	always @(posedge clk_i) begin
		if (rst_i) begin
			contact_iface_on_o <= 1'b1;
			internal_pad_supply_on_o <= 1'b0;
			usb_line_sw_override_o <= 1'b0;
			host_port_select_o <= `PCU_HOST_NONE;
			host_port_invalid_o <= 1'b0;
		end else begin
			contact_iface_on_o <= sysctl_r[`PCU_SYS_CONTACT_IFACE_ON];
			internal_pad_supply_on_o <=
				sysctl_r[`PCU_SYS_INTERNAL_PAD_SUPPLY_ON];
			usb_line_sw_override_o <=
				sysctl_r[`PCU_SYS_USB_LINE_SW_OVERRIDE];
			host_port_select_o <=
				sysctl_r[`PCU_SYS_HOST_SEL_MSB:`PCU_SYS_HOST_SEL_LSB];
			// Codes above the USB code select nothing valid
			host_port_invalid_o <=
				(sysctl_r[`PCU_SYS_HOST_SEL_MSB:`PCU_SYS_HOST_SEL_LSB] >
				`PCU_HOST_USB);
		end
	end

	// ----------------------------------------------------------------
	// Automatic supply reactions
	// ----------------------------------------------------------------

	// Low VBUS only counts while auto powerdown is armed
	assign vbus_trip = vbus_low_i &
		sysctl_r[`PCU_SYS_AUTO_HARD_POWERDOWN];
	// Fresh drop of VBUSP while auto shutdown is armed
	assign vbusp_trip = vbusp_low_i & ~vbusp_low_r &
		sysctl_r[`PCU_SYS_AUTO_CONTACT_SHUTDOWN];

	// Previous VBUSP comparator level for edge detection
	always @(posedge clk_i) begin
		if (rst_i) begin
			vbusp_low_r <= 1'b0;
		end else begin
			vbusp_low_r <= vbusp_low_i;
		end
	end

	// Powerdown holds until reset; shutdown start is one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			hard_powerdown_state_o <= 1'b0;
			contact_shutdown_start_o <= 1'b0;
		end else begin
			if (vbus_trip) begin
				hard_powerdown_state_o <= 1'b1;
			end
			contact_shutdown_start_o <= vbusp_trip;
		end
	end

	// ----------------------------------------------------------------
	// Supply monitors and interrupts
	// ----------------------------------------------------------------
	pcu_supply_mon #(
		.N(2)
	) u_mon (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.low_18_i({aux_pad_supply_low_18_i, pad_supply_low_18_i}),
		.low_33_i({aux_pad_supply_low_33_i, pad_supply_low_33_i}),
		.level_sel_i({sysctl_r[`PCU_SYS_AUX_PAD_SUPPLY_LEVEL_SEL],
			sysctl_r[`PCU_SYS_PAD_SUPPLY_LEVEL_SEL]}),
		.irq_on_i({sysctl_r[`PCU_SYS_AUX_PAD_SUPPLY_IRQ_ON],
			sysctl_r[`PCU_SYS_PAD_SUPPLY_IRQ_ON]}),
		.event_o(mon_ev[1:0])
	);

	// Powerdown entry and shutdown start are also reported
	assign mon_ev[`PCU_IRQ_HARD_POWERDOWN] = vbus_trip & ~hard_powerdown_state_o;
	assign mon_ev[`PCU_IRQ_CONTACT_SHUTDOWN] = vbusp_trip;
	assign ev = mon_ev;

	pcu_irq_core #(
		.W(`PCU_IRQ_BITS)
	) u_irq (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.event_i(ev),
		.flag_set_i(wr_bits & {`PCU_IRQ_BITS{wr_take & sel_flag_set}}),
		.flag_clr_i(wr_bits & {`PCU_IRQ_BITS{wr_take & sel_flag_clr}}),
		.en_set_i(wr_bits & {`PCU_IRQ_BITS{wr_take & sel_en_set}}),
		.en_clr_i(wr_bits & {`PCU_IRQ_BITS{wr_take & sel_en_clr}}),
		.status_o(status),
		.enable_o(enable),
		.irq_o(irq_o)
	);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------

	// Write-only and unmapped words read as zero
	always @* begin
		rdata_nxt = 32'h00000000;
		case (wb_adr_i)
			`PCU_OFS_SCRATCH0: rdata_nxt = scratch_value_0_r;
			`PCU_OFS_SCRATCH1: rdata_nxt = scratch_value_1_r;
			`PCU_OFS_SCRATCH2: rdata_nxt = scratch_value_2_r;
			`PCU_OFS_SYSCTL: begin
				rdata_nxt[`PCU_SYS_USED_MSB:0] = sysctl_r;
			end
			`PCU_OFS_IRQ_STATUS: begin
				rdata_nxt[`PCU_IRQ_BITS-1:0] = status;
			end
			`PCU_OFS_IRQ_EN_VIEW: begin
				rdata_nxt[`PCU_IRQ_BITS-1:0] = enable;
			end
			default: rdata_nxt = 32'h00000000;
		endcase
	end

	// Read data launched with ack, zero otherwise
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req & ~wb_ack_o & ~wb_we_i) begin
			wb_dat_o <= rdata_nxt;
		end else begin
			wb_dat_o <= 32'h00000000;
		end
	end

endmodule // pcu_regs

// ### verilog/pcu_supply_mon.v
`timescale 1ns/1ps
// Supply monitors: pick trigger level, flag a fresh drop below it
module pcu_supply_mon #(
	parameter N = 2
) (
	input wire clk_i,
	input wire rst_i,
	input wire [N-1:0] low_18_i,
	input wire [N-1:0] low_33_i,
	input wire [N-1:0] level_sel_i,
	input wire [N-1:0] irq_on_i,
	output wire [N-1:0] event_o
);
	genvar g;
	generate
		for (g = 0; g < N; g = g + 1) begin : g_mon
			reg below_r;
			wire below_nxt;
			// Level select: zero is the 1.8 V trip, one the 3.3 V trip
			assign below_nxt = level_sel_i[g] ? low_33_i[g] : low_18_i[g];
			// Previous comparator state for crossing detection
			always @(posedge clk_i) begin
				if (rst_i) begin
					below_r <= 1'b0;
				end else begin
					below_r <= below_nxt;
				end
			end
			// Only an enabled crossing raises an event
			assign event_o[g] = below_nxt & ~below_r & irq_on_i[g];
		end
	endgenerate
endmodule // pcu_supply_mon
